/* rtl/usb_ls_link.v */
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "usb_ls_defines.vh"
module usb_ls_link (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rd_data_o,
  input wire dp_i,
  input wire dm_i,
  output reg dp_o,
  output reg dm_o,
  output reg line_oe_n_o,
  output reg suspend_o,
  output reg bus_reset_o
);

  localparam R_IDLE = 2'h0;
  localparam R_SYNC = 2'h1;
  localparam R_PKT = 2'h2;
  localparam T_IDLE = 3'h0;
  localparam T_SYNC = 3'h1;
  localparam T_PID = 3'h2;
  localparam T_DATA = 3'h3;
  localparam T_CRC = 3'h4;
  localparam T_SE0 = 3'h5;
  localparam T_J = 3'h6;

  // data packet id test, used by receive and transmit paths
  function is_data_pid;
    input [3:0] pid;
    begin
      is_data_pid = (pid == `PID_DATA0) || (pid == `PID_DATA1);
    end
  endfunction

  function is_token_pid;
    input [3:0] pid;
    begin
      is_token_pid = (pid == `PID_IN) || (pid == `PID_OUT) || (pid == `PID_SETUP);
    end
  endfunction

  // line state; J reads as dm high with dp low
  wire se0 = ~dp_i & ~dm_i;
  wire lvl_j = dm_i & ~dp_i;
  wire lvl = dm_i;
  wire soft_rst = rst_i | bus_reset_o;

  reg [8:0] se0_cnt_ff;
  reg se0_d_ff;
  reg lvl_d_ff;
  reg [6:0] ph_ff;
  reg [1:0] r_state_ff;
  reg prev_lvl_ff;
  reg [2:0] r_ones_ff;
  reg [6:0] nbits_ff;
  reg [7:0] sr_ff;
  reg [15:0] tok_ff;
  reg [3:0] pid_ff;
  reg [7:0] q1_ff;
  reg [7:0] q2_ff;
  reg [1:0] qn_ff;
  reg tok_match_ff;
  reg [7:0] rx_data_ff;
  reg [3:0] tok_pid_ff;
  reg [1:0] tok_ep_ff;
  reg set_tok_ff, set_data_ff, set_crc_ff, set_stuff_ff, set_tout_ff;
  reg [6:0] bus_id_ff;
  reg wake_ff;
  reg [6:0] flags_ff;
  reg busrst_d_ff;
  reg [3:0] tx_pid_ff;
  reg [7:0] hold_ff;
  reg hold_full_ff;
  reg [2:0] t_state_ff;
  reg [7:0] tx_sr_ff;
  reg [3:0] tx_cnt_ff;
  reg [2:0] tx_ones_ff;
  reg tx_lvl_ff;

  // end of packet: SE0 long enough, not a reset, and ended by J
  wire se0_end = se0_d_ff & ~se0;
  wire eop_ok = se0_end & lvl_j & (se0_cnt_ff >= `EOP_MIN_CYC) & (se0_cnt_ff < `BUS_RST_CYC);
  wire sample = (ph_ff == `BIT_HALF) & ~se0;
  wire r_bit = (lvl == prev_lvl_ff);
  wire unstuff = (r_ones_ff == 3'h6);
  wire tx_busy = (t_state_ff != T_IDLE);
  wire rx_take = (r_state_ff == R_PKT) & sample & ~unstuff;
  wire [6:0] tok_addr = tok_ff[6:0];
  wire [3:0] tok_ep = tok_ff[10:7];

  // crc engines; crc16 is shared by receive and transmit, crc5 is receive only
  wire [4:0] crc5_val;
  wire [15:0] crc16_val;
  wire bit_en;
  wire tx_start = wr_i & (addr_i == `REG_TX_PID) & ~tx_busy & ~wake_ff;
  wire rx_crc_init = (r_state_ff == R_SYNC);
  wire stuff_now = (tx_ones_ff == 3'h6);
  reg cur_bit;
  wire send_bit = stuff_now ? 1'b0 : cur_bit;
  wire tx_crc_en = bit_en & (t_state_ff == T_DATA) & ~stuff_now;
  wire c16_init = tx_start | (~tx_busy & rx_crc_init); // tx_start only exists while idle, so seed it directly
  wire c16_en = tx_busy ? tx_crc_en : (rx_take & (nbits_ff >= 7'h08) & is_data_pid(pid_ff));
  wire c16_din = tx_busy ? send_bit : r_bit;

  serial_crc #(.WIDTH(5), .POLY(`CRC5_POLY)) u_crc5 (
    .clk_sys_i(clk_sys_i),
    .rst_i(soft_rst),
    .init_i(rx_crc_init),
    .en_i(rx_take & (nbits_ff >= 7'h08) & (nbits_ff < `TOKEN_BITS)),
    .din_i(r_bit),
    .crc_o(crc5_val)
  );

  serial_crc #(.WIDTH(16), .POLY(`CRC16_POLY)) u_crc16 (
    .clk_sys_i(clk_sys_i),
    .rst_i(soft_rst),
    .init_i(c16_init),
    .en_i(c16_en),
    .din_i(c16_din),
    .crc_o(crc16_val)
  );

  bit_clock_div #(.STEP(`DIV_STEP), .MODULUS(`DIV_MOD)) u_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(soft_rst),
    .clr_i(tx_start),
    .bit_en_o(bit_en)
  );

  // se0 length and bus reset; only the power-on reset clears this tracker
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      se0_cnt_ff <= 9'h000;
      se0_d_ff <= 1'b0;
      lvl_d_ff <= 1'b1;
      bus_reset_o <= 1'b0;
      busrst_d_ff <= 1'b0;
    end
    else
    begin
      se0_d_ff <= se0;
      lvl_d_ff <= lvl;
      busrst_d_ff <= bus_reset_o;
      if (!se0)
        se0_cnt_ff <= 9'h000;
      else if (se0_cnt_ff != 9'h1FF)
        se0_cnt_ff <= se0_cnt_ff + 9'h001;
      // 2.5 us threshold sits just below the 4..8 bit window and before 5.5 us
      if (se0 && se0_cnt_ff >= `BUS_RST_CYC - 1)
        bus_reset_o <= 1'b1;
      else if (!se0)
        bus_reset_o <= 1'b0;
    end
  end

  // receive bit phase, resynchronised on every data edge
  always @(posedge clk_sys_i)
  begin
    if (soft_rst || se0 || lvl != lvl_d_ff)
      ph_ff <= 7'h00;
    else if (ph_ff == `BIT_CYC - 1)
      ph_ff <= 7'h00;
    else
      ph_ff <= ph_ff + 7'h01;
  end

  // receive state machine
  always @(posedge clk_sys_i)
  begin
    if (soft_rst)
    begin
      r_state_ff <= R_IDLE;
      prev_lvl_ff <= 1'b1;
      r_ones_ff <= 3'h0;
      nbits_ff <= 7'h00;
      sr_ff <= 8'h00;
      tok_ff <= 16'h0000;
      pid_ff <= 4'h0;
      q1_ff <= 8'h00;
      q2_ff <= 8'h00;
      qn_ff <= 2'h0;
      tok_match_ff <= 1'b0;
      rx_data_ff <= 8'h00;
      tok_pid_ff <= 4'h0;
      tok_ep_ff <= 2'h0;
      set_tok_ff <= 1'b0;
      set_data_ff <= 1'b0;
      set_crc_ff <= 1'b0;
      set_stuff_ff <= 1'b0;
      set_tout_ff <= 1'b0;
    end
    else
    begin
      set_tok_ff <= 1'b0;
      set_data_ff <= 1'b0;
      set_crc_ff <= 1'b0;
      set_stuff_ff <= 1'b0;
      set_tout_ff <= 1'b0;
      if (sample)
        prev_lvl_ff <= lvl;
      case (r_state_ff)
        R_IDLE:
        begin
          // packet starts on the J to K move while we are not talking
          if (!tx_busy && lvl_d_ff && !lvl && !se0)
          begin
            r_state_ff <= R_SYNC;
            prev_lvl_ff <= 1'b1;
            nbits_ff <= 7'h00;
          end
        end
        R_SYNC:
        begin
          if (sample)
          begin
            sr_ff <= {r_bit, sr_ff[7:1]};
            nbits_ff <= nbits_ff + 7'h01;
            if (nbits_ff == 7'h07)
            begin
              nbits_ff <= 7'h00;
              r_ones_ff <= r_bit ? 3'h1 : 3'h0;
              r_state_ff <= ({r_bit, sr_ff[7:1]} == `SYNC_BYTE) ? R_PKT : R_IDLE;
            end
          end
          else if (se0)
            r_state_ff <= R_IDLE;
        end
        R_PKT:
        begin
          if (sample && unstuff)
          begin
            r_ones_ff <= 3'h0;
            if (r_bit)
            begin
              set_stuff_ff <= 1'b1;
              r_state_ff <= R_IDLE;
            end
          end
          else if (rx_take)
          begin
            r_ones_ff <= r_bit ? r_ones_ff + 3'h1 : 3'h0;
            nbits_ff <= nbits_ff + 7'h01;
            sr_ff <= {r_bit, sr_ff[7:1]};
            if (nbits_ff >= 7'h08)
              tok_ff <= {r_bit, tok_ff[15:1]};
            if (nbits_ff == 7'h07)
            begin
              pid_ff <= r_bit ? sr_ff[4:1] : sr_ff[4:1];
              // complement check on the packet id byte
              if ({r_bit, sr_ff[7:5]} != ~sr_ff[4:1])
              begin
                set_crc_ff <= 1'b1;
                r_state_ff <= R_IDLE;
              end
            end
            // byte boundary in a data packet: keep two bytes back as crc
            if (nbits_ff[2:0] == 3'h7 && nbits_ff > 7'h07 && is_data_pid(pid_ff))
            begin
              q1_ff <= {r_bit, sr_ff[7:1]};
              q2_ff <= q1_ff;
              if (qn_ff == 2'h2)
              begin
                if (tok_match_ff)
                begin
                  rx_data_ff <= q2_ff;
                  set_data_ff <= 1'b1;
                end
              end
              else
                qn_ff <= qn_ff + 2'h1;
            end
            if (nbits_ff >= `MAX_PKT_BITS)
            begin
              set_tout_ff <= 1'b1;
              r_state_ff <= R_IDLE;
            end
          end
          else if (se0_end)
          begin
            r_state_ff <= R_IDLE;
            qn_ff <= 2'h0;
            if (eop_ok && is_token_pid(pid_ff))
            begin
              if (nbits_ff != `TOKEN_BITS || crc5_val != `CRC5_RESIDUE)
                set_crc_ff <= 1'b1;
              else if (tok_addr == bus_id_ff && tok_ep <= `EP_MAX)
              begin
                tok_match_ff <= 1'b1;
                tok_pid_ff <= pid_ff;
                tok_ep_ff <= tok_ep[1:0];
                set_tok_ff <= 1'b1;
              end
              else
                tok_match_ff <= 1'b0;
            end
            else if (eop_ok && is_data_pid(pid_ff) && tok_match_ff)
            begin
              if (nbits_ff[2:0] != 3'h0 || nbits_ff < 7'h18 || crc16_val != `CRC16_RESIDUE)
                set_crc_ff <= 1'b1;
            end
            else if (eop_ok && nbits_ff == 7'h08 && tok_match_ff)
            begin
              tok_pid_ff <= pid_ff;
              set_tok_ff <= 1'b1;
            end
            else if (!eop_ok)
              set_tout_ff <= 1'b1;
          end
        end
        default: r_state_ff <= R_IDLE;
      endcase
    end
  end

  // next transmit bit, LSB first; crc goes out inverted, MSB first
  always @*
  begin
    if (t_state_ff == T_CRC)
      cur_bit = ~crc16_val[4'hF - tx_cnt_ff];
    else
      cur_bit = tx_sr_ff[0];
  end

  // transmit state machine and line drivers
  always @(posedge clk_sys_i)
  begin
    if (soft_rst)
    begin
      t_state_ff <= T_IDLE;
      tx_sr_ff <= 8'h00;
      tx_cnt_ff <= 4'h0;
      tx_ones_ff <= 3'h0;
      tx_lvl_ff <= 1'b1;
      dp_o <= 1'b0;
      dm_o <= 1'b0;
      line_oe_n_o <= 1'b1;
    end
    else
    begin
      case (t_state_ff)
        T_IDLE:
        begin
          tx_ones_ff <= 3'h0;
          tx_cnt_ff <= 4'h0;
          tx_lvl_ff <= 1'b1;
          if (tx_start)
          begin
            t_state_ff <= T_SYNC;
            tx_sr_ff <= `SYNC_BYTE;
            dp_o <= 1'b0;
            dm_o <= 1'b1;
            line_oe_n_o <= 1'b0;
          end
          else if (wake_ff)
          begin
            // firmware alone times the wake pulse
            dp_o <= 1'b1;
            dm_o <= 1'b0;
            line_oe_n_o <= 1'b0;
          end
          else
          begin
            dp_o <= 1'b0;
            dm_o <= 1'b0;
            line_oe_n_o <= 1'b1;
          end
        end
        T_SYNC, T_PID, T_DATA, T_CRC:
        begin
          if (bit_en)
          begin
            tx_lvl_ff <= send_bit ? tx_lvl_ff : ~tx_lvl_ff;
            dp_o <= send_bit ? ~tx_lvl_ff : tx_lvl_ff;
            dm_o <= send_bit ? tx_lvl_ff : ~tx_lvl_ff;
            tx_ones_ff <= send_bit ? tx_ones_ff + 3'h1 : 3'h0;
            if (!stuff_now)
            begin
              tx_sr_ff <= {1'b0, tx_sr_ff[7:1]};
              tx_cnt_ff <= tx_cnt_ff + 4'h1;
              if (t_state_ff != T_CRC && tx_cnt_ff == 4'h7)
              begin
                tx_cnt_ff <= 4'h0;
                if (t_state_ff == T_SYNC)
                begin
                  t_state_ff <= T_PID;
                  tx_sr_ff <= {~tx_pid_ff, tx_pid_ff};
                end
                else if (!is_data_pid(tx_pid_ff))
                  t_state_ff <= T_SE0;
                else if (hold_full_ff)
                begin
                  t_state_ff <= T_DATA;
                  tx_sr_ff <= hold_ff;
                end
                else
                  t_state_ff <= T_CRC;
              end
              else if (t_state_ff == T_CRC && tx_cnt_ff == 4'hF)
              begin
                tx_cnt_ff <= 4'h0;
                t_state_ff <= T_SE0;
              end
            end
          end
        end
        T_SE0:
        begin
          if (bit_en && stuff_now)
          begin
            // a trailing run of six ones still needs its stuffed zero
            tx_lvl_ff <= ~tx_lvl_ff;
            dp_o <= tx_lvl_ff;
            dm_o <= ~tx_lvl_ff;
            tx_ones_ff <= 3'h0;
          end
          else if (bit_en)
          begin
            dp_o <= 1'b0;
            dm_o <= 1'b0;
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == 4'h1)
            begin
              tx_cnt_ff <= 4'h0;
              t_state_ff <= T_J;
            end
          end
        end
        T_J:
        begin
          if (bit_en && tx_cnt_ff == 4'h0)
          begin
            dp_o <= 1'b0;
            dm_o <= 1'b1;
            tx_cnt_ff <= 4'h1;
          end
          else if (bit_en)
          begin
            line_oe_n_o <= 1'b1;
            dp_o <= 1'b0;
            dm_o <= 1'b0;
            t_state_ff <= T_IDLE;
          end
        end
        default: t_state_ff <= T_IDLE;
      endcase
    end
  end

  wire wr_irq = wr_i & (addr_i == `REG_IRQ0);
  wire tx_take = (t_state_ff == T_PID || t_state_ff == T_DATA) & bit_en & ~stuff_now
    & (tx_cnt_ff == 4'h7) & is_data_pid(tx_pid_ff) & hold_full_ff;
  wire [6:0] flag_set = {set_tout_ff, set_stuff_ff, set_crc_ff, set_data_ff, set_tok_ff, eop_ok,
    bus_reset_o == 1'b0 && busrst_d_ff == 1'b1};

  // software registers; a bus reset clears address and wakes the device
  always @(posedge clk_sys_i)
  begin
    if (soft_rst)
    begin
      bus_id_ff <= 7'h00;
      wake_ff <= 1'b0;
      suspend_o <= 1'b0;
      tx_pid_ff <= 4'h0;
      hold_ff <= 8'h00;
      hold_full_ff <= 1'b0;
    end
    else
    begin
      if (wr_i && addr_i == `REG_BUS_ID)
        bus_id_ff <= wr_data_i[6:0];
      if (wr_i && addr_i == `REG_CTRL1)
        wake_ff <= wr_data_i[`CTRL_WAKE];
      if (wr_irq)
        suspend_o <= wr_data_i[`IRQ_LOW_POWER];
      if (tx_start)
        tx_pid_ff <= wr_data_i[3:0];
      if (wr_i && addr_i == `REG_TX_DATA)
      begin
        hold_ff <= wr_data_i;
        hold_full_ff <= 1'b1;
      end
      else if (tx_take)
        hold_full_ff <= 1'b0;
    end
  end

  // sticky flags survive the bus reset so its own flag can be seen; set wins over clear
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
      flags_ff <= 7'h00;
    else
      flags_ff <= (flags_ff & ~(wr_irq ? wr_data_i[6:0] & `IRQ_FLAG_MASK : 7'h00)) | flag_set;
  end

  // read port: data stand only in the cycle after the strobe
  always @(posedge clk_sys_i)
  begin
    if (soft_rst || !rd_i)
      rd_data_o <= 8'h00;
    else
    begin
      case (addr_i)
        `REG_BUS_ID: rd_data_o <= {1'b0, bus_id_ff};
        `REG_CTRL1: rd_data_o <= {7'h00, wake_ff};
        `REG_IRQ0: rd_data_o <= {suspend_o, flags_ff};
        `REG_TOKEN: rd_data_o <= {2'h0, tok_ep_ff, tok_pid_ff};
        `REG_RX_DATA: rd_data_o <= rx_data_ff;
        `REG_TX_PID: rd_data_o <= {6'h00, ~hold_full_ff, tx_busy};
        default: rd_data_o <= 8'h00;
      endcase
    end
  end

endmodule // usb_ls_link

/* include/usb_ls_defines.vh */
`ifndef USB_LS_DEFINES_VH
`define USB_LS_DEFINES_VH

// timing
`define CLK_MHZ 100
`define CLK_KHZ 100000
`define BIT_KHZ 1500
`define BIT_CYC ((`CLK_KHZ + `BIT_KHZ - 1) / `BIT_KHZ)
`define BIT_HALF (`BIT_CYC / 2)
`define EOP_REJECT_NS 330
`define EOP_MIN_CYC ((`EOP_REJECT_NS * `CLK_MHZ + 999) / 1000)
`define BUS_RST_NS 2500
`define BUS_RST_CYC ((`BUS_RST_NS * `CLK_MHZ + 999) / 1000)
`define DIV_STEP 3
`define DIV_MOD 200

// packet ids and framing
`define PID_IN 4'h9
`define PID_OUT 4'h1
`define PID_SETUP 4'hD
`define PID_DATA0 4'h3
`define PID_DATA1 4'hB
`define PID_ACK 4'h2
`define PID_NAK 4'hA
`define PID_STALL 4'hE
`define SYNC_BYTE 8'h80
`define EP_MAX 4'h2
`define TOKEN_BITS 7'h18
`define MAX_PKT_BITS 7'h58

// crc
`define CRC5_POLY 5'h05
`define CRC5_RESIDUE 5'h0C
`define CRC16_POLY 16'h8005
`define CRC16_RESIDUE 16'h800D

// register map
`define REG_BUS_ID 3'h0
`define REG_CTRL1 3'h1
`define REG_IRQ0 3'h2
`define REG_TOKEN 3'h3
`define REG_RX_DATA 3'h4
`define REG_TX_PID 3'h5
`define REG_TX_DATA 3'h6

// usb_irq_reg_zero bits
`define IRQ_BUS_RST 0
`define IRQ_PKT_END 1
`define IRQ_TOKEN 2
`define IRQ_RX_DATA 3
`define IRQ_CRC_ERR 4
`define IRQ_STUFF_ERR 5
`define IRQ_TIMEOUT 6
`define IRQ_LOW_POWER 7
`define IRQ_FLAG_MASK 7'h7F

// usb_control_reg_one bits
`define CTRL_WAKE 0

`endif

/* rtl/serial_crc.v */
`timescale 1ns/1ps
// one-bit-per-step usb crc, register seeded with all ones
module serial_crc #(
  parameter WIDTH = 5,
  parameter [WIDTH-1:0] POLY = 5'h05
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire init_i,
  input wire en_i,
  input wire din_i,
  output reg [WIDTH-1:0] crc_o
);

  wire fb;

  assign fb = din_i ^ crc_o[WIDTH-1];

  // galois shift; init wins so a new packet never inherits stale state
  always @(posedge clk_sys_i)
  begin
    if (rst_i || init_i)
      crc_o <= {WIDTH{1'b1}};
    else if (en_i)
      crc_o <= {crc_o[WIDTH-2:0], 1'b0} ^ (fb ? POLY : {WIDTH{1'b0}});
  end

endmodule // serial_crc

/* rtl/bit_clock_div.v */
`timescale 1ns/1ps
// fractional divider: one enable pulse per bit time
module bit_clock_div #(
  parameter STEP = 3,
  parameter MODULUS = 200
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire clr_i,
  output reg bit_en_o
);

  reg [15:0] acc_ff;
  wire [15:0] nxt_acc;

  assign nxt_acc = acc_ff + STEP[15:0];

  // phase accumulator keeps the long-run rate exact despite the odd ratio
  always @(posedge clk_sys_i)
  begin
    if (rst_i || clr_i)
    begin
      acc_ff <= 16'h0000;
      bit_en_o <= 1'b0;
    end
    else if (nxt_acc >= MODULUS[15:0])
    begin
      acc_ff <= nxt_acc - MODULUS[15:0];
      bit_en_o <= 1'b1;
    end
    else
    begin
      acc_ff <= nxt_acc;
      bit_en_o <= 1'b0;
    end
  end

endmodule // bit_clock_div

/* bench/usb_ls_link_chk.sv */
`timescale 1ns/1ps
module usb_ls_link_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic dp_o,
  input wire logic dm_o,
  input wire logic line_oe_n_o,
  input wire logic suspend_o,
  input wire logic bus_reset_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [8:0] se0_ff;
  logic [7:0] tx_se0_ff;
  logic wake_ff;
  wire drv_se0 = !line_oe_n_o && !dp_o && !dm_o;
  wire drv_j = !line_oe_n_o && !dp_o && dm_o;
  wire wake_wr = wr_i && addr_i == 3'h1;
  // run lengths of seen and driven se0; wake only counts if it started with the line free
  always @(posedge clk_sys_i)
  begin
    se0_ff <= (rst_i || dp_i || dm_i) ? 9'h000 : (se0_ff == 9'h12C ? se0_ff : se0_ff + 9'h001);
    tx_se0_ff <= drv_se0 ? tx_se0_ff + 8'h01 : 8'h00;
    wake_ff <= (rst_i || bus_reset_o) ? 1'b0 : (wake_wr ? wr_data_i[0] && (wake_ff || line_oe_n_o) : wake_ff);
  end
  sequence eop_end_s;
    drv_se0 ##1 drv_j;
  endsequence
  sequence idle_float_s;
    drv_j [*8] ##[50:62] line_oe_n_o;
  endsequence
  rst_seen_a: assert property (se0_ff >= 9'h0FC |-> bus_reset_o)
    else $error("long se0 not taken as bus reset");
  rst_early_a: assert property ($rose(bus_reset_o) |-> se0_ff >= 9'h0F9)
    else $error("bus reset raised on short se0");
  rst_end_a: assert property (bus_reset_o && (dp_i || dm_i) |=> !bus_reset_o)
    else $error("bus reset outlived the se0");
  eop_width_a: assert property (tx_se0_ff != 8'h00 && !drv_se0 |-> tx_se0_ff >= 8'h7D && tx_se0_ff <= 8'h96 && drv_j)
    else $error("driven eop se0 width or following j wrong");
  eop_float_a: assert property (eop_end_s |-> idle_float_s)
    else $error("idle bit after eop not one bit then float");
  wake_k_a: assert property (wake_ff |=> dp_o && !dm_o && !line_oe_n_o)
    else $error("k not driven while wake bit set");
  wake_off_a: assert property ($fell(wake_ff) |=> line_oe_n_o)
    else $error("lines not floated after wake cleared");
  susp_set_a: assert property (wr_i && addr_i == 3'h2 && !bus_reset_o |=> suspend_o == $past(wr_data_i[7]))
    else $error("suspend does not follow its bit");
  susp_hold_a: assert property (!(wr_i && addr_i == 3'h2) |=> $stable(suspend_o) || bus_reset_o)
    else $error("suspend changed on its own");
  rst_wake_a: assert property (bus_reset_o |-> ##2 !suspend_o)
    else $error("bus reset left device suspended");
endmodule // usb_ls_link_chk

/* bench/usb_host_model.sv */
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clk_sys_i,
  input wire logic dp_o,
  input wire logic dm_o,
  input wire logic line_oe_n_o,
  output logic dp_i,
  output logic dm_i
);
  logic drv_ff = 1'b0;
  logic hp_ff = 1'b0;
  logic hm_ff = 1'b1;
  logic k_ff = 1'b0;
  // device wins, then host; released line sits at j through the minus-line pull-up
  assign dp_i = (line_oe_n_o === 1'b0) ? dp_o : (drv_ff ? hp_ff : 1'b0);
  assign dm_i = (line_oe_n_o === 1'b0) ? dm_o : (drv_ff ? hm_ff : 1'b1);
  task automatic hold(input logic p, input logic m, input int n);
    begin
      drv_ff <= 1'b1;
      hp_ff <= p;
      hm_ff <= m;
      repeat (n) @(posedge clk_sys_i);
    end
  endtask
  // se0 then one j bit, then let go
  task automatic se0_j(input int n);
    begin
      hold(1'b0, 1'b0, n);
      hold(1'b0, 1'b1, 67);
      drv_ff <= 1'b0;
      k_ff = 1'b0;
    end
  endtask
  // 67 clocks a bit is slightly slow, harmless over a short token
  task automatic send(input logic [31:0] v, input int n);
    int i;
    int ones;
    begin
      ones = 0;
      for (i = 0; i < n; i++)
      begin
        k_ff = v[i] ? k_ff : !k_ff;
        ones = v[i] ? ones + 1 : 0;
        hold(k_ff, !k_ff, 67);
        if (ones == 6)
        begin
          k_ff = !k_ff;
          ones = 0;
          hold(k_ff, !k_ff, 67);
        end
      end
      se0_j(134);
    end
  endtask
endmodule // usb_host_model

/* bench/usb_ls_link_bench.sv */
`timescale 1ns/1ps
module usb_ls_link_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rd_data_o;
  logic dp_i, dm_i, dp_o, dm_o, line_oe_n_o, suspend_o, bus_reset_o;
  logic [7:0] rv;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial forever #5 clk_sys_i = !clk_sys_i;
  usb_ls_link usb_ls_link_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .dp_i(dp_i), .dm_i(dm_i), .dp_o(dp_o), .dm_o(dm_o),
    .line_oe_n_o(line_oe_n_o), .suspend_o(suspend_o), .bus_reset_o(bus_reset_o));
  usb_host_model usb_host_model_inst (.clk_sys_i(clk_sys_i), .dp_o(dp_o), .dm_o(dm_o),
    .line_oe_n_o(line_oe_n_o), .dp_i(dp_i), .dm_i(dm_i));
  task automatic tick;
    begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        fails++;
        $display("BAD %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    begin
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    begin
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 rv = rd_data_o;
    end
  endtask
  // field value sent lsb first, so the top crc bit lands in bit 0
  function automatic logic [4:0] crc5(input logic [10:0] d);
    logic [4:0] c;
    int i;
    begin
      c = 5'h1F;
      for (i = 0; i < 11; i++)
        c = {c[3:0], 1'b0} ^ ((d[i] ^ c[4]) ? 5'h05 : 5'h00);
      crc5 = ~{c[0], c[1], c[2], c[3], c[4]};
    end
  endfunction
  task automatic token(input logic [6:0] a, input logic [3:0] ep, input logic [4:0] flip, input logic ok);
    begin
      wr(3'h2, 8'h7F);
      usb_host_model_inst.send({crc5({ep, a}) ^ flip, ep, a, 4'h6, 4'h9, 8'h80}, 32);
      repeat (10) tick;
      rd(3'h2);
      check("token accepted", ok, rv[2]);
      check("crc error", |flip, rv[4]);
      check("packet end", 1'b1, rv[1]);
      rd(3'h3);
      if (ok) check("token reg", {2'h0, ep[1:0], 4'h9}, rv);
      $display("token test done");
    end
  endtask
  task automatic eop_test(input int n, input logic ok);
    begin
      wr(3'h2, 8'h7F);
      usb_host_model_inst.hold(1'b1, 1'b0, 200); // resume k, shortened to fit the run
      usb_host_model_inst.se0_j(n);
      repeat (4) tick;
      rd(3'h2);
      check("eop flag", ok, rv[1]);
      $display("eop test done");
    end
  endtask
  // empty data packet after an accepted token; crc of nothing is all zeros on the wire
  task automatic data_rx(input logic [15:0] crc, input logic bad);
    begin
      wr(3'h2, 8'h7F);
      usb_host_model_inst.send({crc, 8'hC3, 8'h80}, 32);
      repeat (10) tick;
      rd(3'h2);
      check("data crc error", bad, rv[4]);
      check("no data byte", 1'b0, rv[3]);
      $display("data test done");
    end
  endtask
  task automatic wake_test;
    begin
      wr(3'h1, 8'h01); // idle wait shortened
      tick;
      check("wake k", 3'h4, {dp_o, dm_o, line_oe_n_o});
      wr(3'h1, 8'h00); // hold time shortened
      tick;
      check("wake float", 1'b1, line_oe_n_o);
      $display("wake test done");
    end
  endtask
  task automatic tx_test;
    logic [15:0] got;
    logic [1:0] prev;
    int c;
    int k;
    begin
      wr(3'h5, 8'h02);
      tick;
      check("tx start j", 3'h2, {dp_o, dm_o, line_oe_n_o});
      c = 0;
      while (dp_o !== 1'b1 && c < 200)
      begin
        tick;
        c++;
      end
      prev = 2'h1;
      c = 0;
      // sample at bit centres, 200/3 clocks per bit
      for (k = 0; k < 19; k++)
      begin
        while (c < (200 * k + 100) / 3)
        begin
          tick;
          c++;
        end
        if (k < 16) got[k] = ({dp_o, dm_o} === prev);
        prev = {dp_o, dm_o};
        if (k >= 16) check("eop symbol", (k < 18) ? 2'h0 : 2'h1, prev);
      end
      check("sync and pid", 16'hD280, got);
      c = 0;
      while (line_oe_n_o !== 1'b1 && c < 80)
      begin
        tick;
        c++;
      end
      check("release", 1'b1, line_oe_n_o);
      $display("transmit test done");
    end
  endtask
  task automatic bus_reset_test;
    begin
      wr(3'h2, 8'h80);
      #1 check("suspend", 1'b1, suspend_o);
      usb_host_model_inst.hold(1'b0, 1'b0, 260);
      #1 check("bus reset", 1'b1, bus_reset_o);
      check("woken", 1'b0, suspend_o);
      usb_host_model_inst.se0_j(40);
      rd(3'h2);
      check("bus reset flag", 1'b1, rv[0]);
      rd(3'h0);
      check("unaddressed", 8'h00, rv);
      wr(3'h0, 8'h05);
      rd(3'h0);
      check("new address", 8'h05, rv);
      $display("bus reset test done");
    end
  endtask
  task automatic results;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // tests need about 19000 cycles; give them headroom
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      $display("BAD run length expected %0d seen %0d", 39999, cyc);
      results;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(3'h7);
    check("unmapped read", 8'h00, rv);
    wr(3'h0, 8'h05);
    token(7'h05, 4'h0, 5'h00, 1'b1);
    token(7'h05, 4'h2, 5'h00, 1'b1);
    data_rx(16'h0000, 1'b0);
    data_rx(16'h0100, 1'b1);
    token(7'h05, 4'h3, 5'h00, 1'b0);
    token(7'h06, 4'h1, 5'h00, 1'b0);
    token(7'h05, 4'h1, 5'h04, 1'b0);
    eop_test(67, 1'b1);
    eop_test(20, 1'b0);
    wake_test;
    tx_test;
    bus_reset_test;
    results;
  end
endmodule // usb_ls_link_bench
bind usb_ls_link usb_ls_link_chk usb_ls_link_chk_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .dp_i(dp_i), .dm_i(dm_i), .dp_o(dp_o), .dm_o(dm_o),
  .line_oe_n_o(line_oe_n_o), .suspend_o(suspend_o), .bus_reset_o(bus_reset_o));
